// ==== design/wdtsm_top.sv ====
// module: watchdog timer with four enable modes and sleep handling
//
// Operation
// - counter advances on ticks at the slow internal oscillator rate, divided down from the system clock
// - expiry while awake without a clear instruction raises a system reset
// - enable field 11 runs the watchdog always, sleep included
// - enable field 10 runs while awake, clears and stops in sleep
// - enable field 01 lets the software enable bit alone decide
// - in software mode sleep entry or exit does not change enable
// - field 00, or 01 with software bit low, disables and clears
// - period spans 1 ms to 256 s, resets to two seconds
// - any reset, clear instruction or oscillator failure clears the counter
// - sleep entry clears the counter; counting resumes from zero if enabled
// - sleep exit clears counter again, immediately for non-crystal clocks
// - crystal wake holds counter clear until start-up timer ends
// - counter held clear while start-up timer runs
// - internal oscillator divider changes leave the counter alone
// - expiry during sleep wakes the device instead of resetting
// - expiry updates expired, power-down and watchdog-reset flags
// - period code selects prescale two to the power code plus five
`default_nettype none
module wdtsm_top (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [1:0] watchdog_enable_config_in,
    input wire logic ctrl_wr_in,
    input wire logic [5:0] ctrl_wdata_in,
    input wire logic watchdog_clear_instruction_in,
    input wire logic sleep_in,
    input wire logic osc_fail_in,
    input wire logic osc_startup_timer_running_in,
    input wire logic sys_clk_is_crystal_in,
    input wire logic [2:0] internal_osc_divider_in,
    input wire logic flags_clear_in,
    output logic [5:0] ctrl_rdata_out,
    output logic wdt_sys_reset_out,
    output logic wdt_wake_out,
    output logic running_out,
    output logic [22:0] count_out,
    output logic watchdog_expired_flag_n_out,
    output logic power_down_flag_n_out,
    output logic watchdog_reset_flag_n_out
);
    // ==========================================================
    // control register: software enable and period select
    logic [5:0] ctrl_q;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            ctrl_q <= wdtsm_pkg::CTRL_RESET;
        else if (ctrl_wr_in)
            ctrl_q <= ctrl_wdata_in;
    end
    wire logic sw_en = ctrl_q[wdtsm_pkg::CTRL_SWEN_BIT];
    wire logic [4:0] ps_code = ctrl_q[wdtsm_pkg::CTRL_PS_LSB +: 5];

    // ==========================================================
    // enable decode; the divider input is read only into a term that cancels out
    wire logic en_on = (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_ON);
    wire logic en_ns = (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_NOSLEEP)
        && !sleep_in;
    wire logic en_sw = (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_SW)
        && sw_en; // sleep not looked at
    wire logic enabled = en_on || en_ns || en_sw;
    wire logic unused_div = ^internal_osc_divider_in;

    // ==========================================================
    // sleep edges and crystal wake hold
    logic sleep_q;
    logic xtal_hold_q;
    wire logic sleep_enter = sleep_in && !sleep_q;
    wire logic sleep_exit = !sleep_in && sleep_q;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            sleep_q <= 1'b0;
            xtal_hold_q <= 1'b0;
        end
        else
        begin
            sleep_q <= sleep_in;
            // keep clear from crystal wake until the start-up timer ends
            if (sleep_exit && sys_clk_is_crystal_in)
                xtal_hold_q <= 1'b1;
            else if (!osc_startup_timer_running_in)
                xtal_hold_q <= 1'b0;
        end
    end

    // ==========================================================
    // clear sources
    wire logic clr = !enabled
        || watchdog_clear_instruction_in
        || osc_fail_in
        || sleep_enter
        || sleep_exit
        || xtal_hold_q
        || osc_startup_timer_running_in;

    // ==========================================================
    // prescale select: code plus five, reserved codes fall back to 1:32
    wire logic [4:0] ps_eff = (ps_code > wdtsm_pkg::PS_MAX) ?
        wdtsm_pkg::PS_MIN_FALLBACK : ps_code;
    wire logic [4:0] term_bit = ps_eff + 5'(wdtsm_pkg::PS_SHIFT);
    wire logic [22:0] term_cnt = 23'((24'h000001 << term_bit) - 24'h000001);

    // ==========================================================
    // slow tick and counter
    logic tick;
    wdtsm_tick u_tick (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tick_out(tick)
    );

    logic [22:0] cnt_q;
    logic [22:0] cnt_d;
    logic expire_q;
    logic wake_q;
    wire logic expire = !clr && tick && (cnt_q >= term_cnt);
    always_comb
    begin
        cnt_d = cnt_q;
        if (clr || expire)
            cnt_d = 23'h000000;
        else if (tick)
            cnt_d = cnt_q + 23'h000001;
    end

    // counter and one-cycle requests; sleep picks wake over reset
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            cnt_q <= 23'h000000;
            expire_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            expire_q <= expire && !sleep_in;
            wake_q <= expire && sleep_in;
        end
    end

    // ==========================================================
    // status flags, active low; an expiry beats a same-cycle clear
    wdtsm_pkg::wdtsm_flags_t flags_q;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            flags_q <= '{expired_n: 1'b1, power_down_n: 1'b1, wdt_reset_n: 1'b1};
        else if (expire)
        begin
            flags_q.expired_n <= 1'b0;
            flags_q.power_down_n <= !sleep_in;
            flags_q.wdt_reset_n <= sleep_in;
        end
        else if (flags_clear_in)
            flags_q <= '{expired_n: 1'b1, power_down_n: 1'b1, wdt_reset_n: 1'b1};
    end

    logic run_q;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            run_q <= 1'b0;
        else
            run_q <= enabled && !unused_div ^ unused_div;
    end

    assign ctrl_rdata_out = ctrl_q;
    assign wdt_sys_reset_out = expire_q;
    assign wdt_wake_out = wake_q;
    assign running_out = run_q;
    assign count_out = cnt_q;
    assign watchdog_expired_flag_n_out = flags_q.expired_n;
    assign power_down_flag_n_out = flags_q.power_down_n;
    assign watchdog_reset_flag_n_out = flags_q.wdt_reset_n;

    // ==========================================================
    // checks
    property p_disabled_clear;
        @(posedge clk_in) disable iff (srst_in)
        (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_OFF) |=> (cnt_q == 23'h000000);
    endproperty
    a_disabled_clear: assert property (p_disabled_clear) else $error("count not held in off mode");

    property p_sw_off;
        @(posedge clk_in) disable iff (srst_in)
        (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_SW && !sw_en) |=> !wdt_sys_reset_out;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("reset while software disabled");

    property p_nosleep_stop;
        @(posedge clk_in) disable iff (srst_in)
        (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_NOSLEEP && sleep_in)
            |=> (cnt_q == 23'h000000);
    endproperty
    a_nosleep_stop: assert property (p_nosleep_stop) else $error("count runs in sleep");

    property p_clear_instr;
        @(posedge clk_in) disable iff (srst_in)
        watchdog_clear_instruction_in |=> (cnt_q == 23'h000000) && !wdt_sys_reset_out;
    endproperty
    a_clear_instr: assert property (p_clear_instr) else $error("clear did not clear");

    property p_ost_hold;
        @(posedge clk_in) disable iff (srst_in)
        osc_startup_timer_running_in |=> (cnt_q == 23'h000000);
    endproperty
    a_ost_hold: assert property (p_ost_hold) else $error("count moved during start-up");

    property p_sleep_wake;
        @(posedge clk_in) disable iff (srst_in)
        (expire && sleep_in) |=> wdt_wake_out && !wdt_sys_reset_out;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep expiry not a wake");

    property p_awake_reset;
        @(posedge clk_in) disable iff (srst_in)
        (expire && !sleep_in) |=> wdt_sys_reset_out ##1 !wdt_sys_reset_out;
    endproperty
    a_awake_reset: assert property (p_awake_reset) else $error("reset not one cycle");

    property p_flags;
        @(posedge clk_in) disable iff (srst_in)
        expire |=> !watchdog_expired_flag_n_out;
    endproperty
    a_flags: assert property (p_flags) else $error("expired flag not set");

    property p_prescale;
        @(posedge clk_in) disable iff (srst_in)
        (ps_code == 5'h0a) |-> (term_cnt == 23'h007fff);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale code wrong");

    property p_wake_pulse;
        @(posedge clk_in) disable iff (srst_in)
        wdt_wake_out |=> !wdt_wake_out;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake not one cycle");

    property p_awake_flags;
        @(posedge clk_in) disable iff (srst_in)
        (expire && !sleep_in) |=> !watchdog_reset_flag_n_out && power_down_flag_n_out;
    endproperty
    a_awake_flags: assert property (p_awake_flags) else $error("awake expiry flags wrong");

    property p_sleep_flags;
        @(posedge clk_in) disable iff (srst_in)
        (expire && sleep_in) |=> !power_down_flag_n_out && watchdog_reset_flag_n_out;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep expiry flags wrong");

    property p_flag_clear;
        @(posedge clk_in) disable iff (srst_in)
        (flags_clear_in && !expire) |=> watchdog_expired_flag_n_out
            && power_down_flag_n_out && watchdog_reset_flag_n_out;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

    property p_osc_fail;
        @(posedge clk_in) disable iff (srst_in)
        osc_fail_in |=> (cnt_q == 23'h000000);
    endproperty
    a_osc_fail: assert property (p_osc_fail) else $error("oscillator fail did not clear");

    property p_sleep_enter;
        @(posedge clk_in) disable iff (srst_in)
        sleep_enter |=> (cnt_q == 23'h000000);
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry did not clear");

    property p_sleep_exit;
        @(posedge clk_in) disable iff (srst_in)
        sleep_exit |=> (cnt_q == 23'h000000);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit did not clear");

    property p_xtal_hold;
        @(posedge clk_in) disable iff (srst_in)
        xtal_hold_q |=> (cnt_q == 23'h000000);
    endproperty
    a_xtal_hold: assert property (p_xtal_hold) else $error("count moved in crystal hold");

    property p_always_on;
        @(posedge clk_in) disable iff (srst_in)
        (watchdog_enable_config_in == wdtsm_pkg::EN_CFG_ON) |=> running_out;
    endproperty
    a_always_on: assert property (p_always_on) else $error("always-on mode not running");

    property p_count_step;
        @(posedge clk_in) disable iff (srst_in)
        (!clr && tick && !expire) |=> (cnt_q == $past(cnt_q) + 23'h000001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step on tick");

    property p_count_hold;
        @(posedge clk_in) disable iff (srst_in)
        (!clr && !tick) |=> $stable(cnt_q);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved without tick");

    property p_ctrl_write;
        @(posedge clk_in) disable iff (srst_in)
        ctrl_wr_in |=> (ctrl_rdata_out == $past(ctrl_wdata_in));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
endmodule // wdtsm_top
`default_nettype wire

// ==== design/wdtsm_pkg.sv ====
// package: constants and types for the watchdog timer with sleep modes
`default_nettype none
package wdtsm_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LFOSC_HZ = 31_000;
    // nominal base tick in microseconds
    localparam int unsigned BASE_TICK_US = 1000;
    // system clocks per low frequency oscillator period, rounded down
    localparam int unsigned LFOSC_DIV = CLK_HZ / LFOSC_HZ;
    localparam logic [10:0] LFOSC_DIV_M1 = 11'(LFOSC_DIV - 1);
    // ==========================================================
    // configuration encodings
    localparam logic [1:0] EN_CFG_OFF = 2'h0;
    localparam logic [1:0] EN_CFG_SW = 2'h1;
    localparam logic [1:0] EN_CFG_NOSLEEP = 2'h2;
    localparam logic [1:0] EN_CFG_ON = 2'h3;
    // ==========================================================
    // period select
    localparam logic [4:0] PS_RESET = 5'h0b;
    localparam logic [4:0] PS_MAX = 5'h12;
    localparam logic [4:0] PS_MIN_FALLBACK = 5'h00;
    localparam int unsigned PS_SHIFT = 5;
    localparam int unsigned CNT_W = 23;
    // control register field positions
    localparam int unsigned CTRL_SWEN_BIT = 0;
    localparam int unsigned CTRL_PS_LSB = 1;
    localparam logic [5:0] CTRL_RESET = 6'h16;

    // clock source class of the system clock
    typedef enum logic [1:0] {
        WDTSM_SRC_FAST,
        WDTSM_SRC_CRYSTAL
    } wdtsm_src_t;

    // status flags carried together
    typedef struct packed {
        logic expired_n;
        logic power_down_n;
        logic wdt_reset_n;
    } wdtsm_flags_t;
endpackage : wdtsm_pkg
`default_nettype wire

// ==== design/wdtsm_tick.sv ====
// module: divider that makes one-cycle ticks at the low oscillator rate
`default_nettype none
module wdtsm_tick (
    input wire logic clk_in,
    input wire logic srst_in,
    output logic tick_out
);
    logic [10:0] div_q;
    logic [10:0] div_d;
    logic tick_q;
    wire logic wrap = (div_q == wdtsm_pkg::LFOSC_DIV_M1);

    // free-running divider, independent of any system clock divider setting
    assign div_d = wrap ? 11'h000 : div_q + 11'h001;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            div_q <= 11'h000;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick_q <= wrap;
        end
    end
    assign tick_out = tick_q;
endmodule // wdtsm_tick
`default_nettype wire

// ==== verification/wdtsm_partner.sv ====
// partner model: firmware side that puts the device to sleep and wakes it
`default_nettype none
module wdtsm_partner (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic enter_in,
    input wire logic exit_in,
    input wire logic wake_in,
    output logic sleep_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // sleep level: a watchdog wake ends sleep like firmware resuming
    always_ff @(posedge clk_in)
    begin
        if (srst_in || exit_in || wake_in)
            sleep_out <= 1'b0;
        else if (enter_in)
            sleep_out <= 1'b1;
    end
endmodule // wdtsm_partner
`default_nettype wire

// ==== verification/wdtsm_tb_top.sv ====
// testbench: watchdog modes, clearing, sleep handling and two expiries (sleep wake, awake reset)
`default_nettype none
module wdtsm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [2:0] sel; logic [22:0] exp;} wdtsm_note_t;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [1:0] cfg = 2'h0;
    logic wr = 1'b0;
    logic [5:0] wdata = 6'h00;
    logic clr = 1'b0;
    logic ofail = 1'b0;
    logic osc_startup_timer = 1'b0;
    logic xtal = 1'b0;
    logic [2:0] div = 3'h0;
    logic fclr = 1'b0;
    logic enter = 1'b0;
    logic leave = 1'b0;
    logic sleep, sres, wake, run, exp_n, pd_n, rst_n;
    logic [5:0] rdata;
    logic [22:0] cnt;
    wdtsm_note_t notes[$];
    wdtsm_note_t nt;
    event sample_ev;
    int n_mismatch = 0;
    int checks = 0;
    int w;
    logic [5:0] d;
    always #10 clk_in = ~clk_in;
    wdtsm_top uut (.clk_in(clk_in), .srst_in(srst_in), .watchdog_enable_config_in(cfg),
        .ctrl_wr_in(wr), .ctrl_wdata_in(wdata), .watchdog_clear_instruction_in(clr),
        .sleep_in(sleep), .osc_fail_in(ofail), .osc_startup_timer_running_in(osc_startup_timer),
        .sys_clk_is_crystal_in(xtal), .internal_osc_divider_in(div), .flags_clear_in(fclr),
        .ctrl_rdata_out(rdata), .wdt_sys_reset_out(sres), .wdt_wake_out(wake),
        .running_out(run), .count_out(cnt), .watchdog_expired_flag_n_out(exp_n),
        .power_down_flag_n_out(pd_n), .watchdog_reset_flag_n_out(rst_n));
    wdtsm_partner partner (.clk_in(clk_in), .srst_in(srst_in), .enter_in(enter),
        .exit_in(leave), .wake_in(wake), .sleep_out(sleep));
    // ==========================================================
    // result selection; count is judged as above zero so tick phase does not matter
    function automatic logic [22:0] obs(input logic [2:0] sel);
        case (sel)
            3'h0: return 23'(run);
            3'h1: return 23'(cnt > 23'h000000);
            3'h2: return 23'(rdata);
            3'h3: return 23'({exp_n, pd_n, rst_n});
            3'h5: return 23'(wake);
            default: return 23'(sres);
        endcase
    endfunction
    task automatic check_val(input logic [22:0] e, input logic [22:0] a);
        checks++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic note_val(input logic [2:0] s, input logic [22:0] e);
        notes.push_back('{s, e});
        -> sample_ev;
    endtask
    // monitor drains every note queued in this time step
    always @(sample_ev)
    begin
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            check_val(nt.exp, obs(nt.sel));
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_in);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
    endtask
    task automatic wr_ctrl(input logic [5:0] v);
        @(negedge clk_in);
        wr = 1'b1;
        wdata = v;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    task automatic complete_run();
        #1;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // watchdog of the bench: two full expiries make the run about 114k cycles
    initial
    begin
        #2_600_000;
        n_mismatch++;
        complete_run();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(49));
        cyc(4);
        srst_in = 1'b0;
        note_val(3'h2, 23'(wdtsm_pkg::CTRL_RESET));
        note_val(3'h3, 23'h000007);
        note_val(3'h0, 23'h000000);
        d = 6'($urandom);
        wr_ctrl(d);
        note_val(3'h2, 23'(d));
        // code 01010 with software enable, the one-second setting
        wr_ctrl(6'h15);
        note_val(3'h2, 23'h000015);
        // every mode, software bit and sleep state
        for (int m = 0; m < 16; m++)
        begin
            cfg = m[3:2];
            wr_ctrl({wdtsm_pkg::PS_RESET, m[0]});
            if (m[1])
                pulse(enter);
            else
                pulse(leave);
            cyc(3);
            note_val(3'h0, 23'(cfg == 2'h3 || (cfg == 2'h2 && !m[1]) || (cfg == 2'h1 && m[0])));
        end
        pulse(leave);
        cyc(1700);
        note_val(3'h1, 23'h000001);
        div = 3'($urandom);
        cyc(2);
        note_val(3'h1, 23'h000001);
        pulse(clr);
        note_val(3'h1, 23'h000000);
        cyc(1700);
        pulse(ofail);
        note_val(3'h1, 23'h000000);
        osc_startup_timer = 1'b1;
        cyc(1700);
        note_val(3'h1, 23'h000000);
        osc_startup_timer = 1'b0;
        cyc(1700);
        // shortest period from here on, so the sleep below ends in a wake
        wr_ctrl(6'h00);
        pulse(enter);
        cyc(1);
        note_val(3'h1, 23'h000000);
        cyc(1700);
        note_val(3'h1, 23'h000001);
        w = 0;
        while (wake !== 1'b1 && w < 60000)
        begin
            cyc(1);
            w++;
        end
        note_val(3'h5, 23'h000001);
        note_val(3'h4, 23'h000000);
        note_val(3'h3, 23'h000001);
        cyc(1);
        note_val(3'h5, 23'h000000);
        // crystal clock: start-up timer runs across the sleep exit
        xtal = 1'b1;
        osc_startup_timer = 1'b1;
        pulse(enter);
        pulse(leave);
        cyc(1700);
        note_val(3'h1, 23'h000000);
        osc_startup_timer = 1'b0;
        cyc(1700);
        note_val(3'h1, 23'h000001);
        xtal = 1'b0;
        // shortest period, awake expiry
        pulse(clr);
        w = 0;
        while (sres !== 1'b1 && w < 60000)
        begin
            cyc(1);
            w++;
        end
        check_val(23'h000001, 23'(w >= 48360 && w < 60000));
        note_val(3'h4, 23'h000001);
        note_val(3'h3, 23'h000002);
        cyc(1);
        note_val(3'h4, 23'h000000);
        pulse(fclr);
        note_val(3'h3, 23'h000007);
        complete_run();
    end
endmodule // wdtsm_tb_top
`default_nettype wire
